// >>> hdl/addr_map_if.sv
// Mapped address and chip-select lines passed from a mapper to the top
`timescale 1ns/1ps
interface addr_map_if;
    logic [15:0] addr;
    logic        cs1;
    logic        cs2;

    modport src (
        output addr,
        output cs1,
        output cs2
    );

    modport dst (
        input addr,
        input cs1,
        input cs2
    );
endinterface

// >>> hdl/addr_mapper.sv
// Splits the top two address bits into chip selects or address bits
`timescale 1ns/1ps
module addr_mapper (
    input  wire logic [1:0]  chip_select_function,
    input  wire logic [15:0] addr_reg,
    addr_map_if.src          map
);

    logic two_is_select;
    logic one_is_select;

    // ************************************************************
    // Chip-select decode
    // ************************************************************

    // Reserved code 11 behaves as plain address mode
    assign two_is_select = (chip_select_function == pmp_pkg::CSF_BOTH) ||
                           (chip_select_function == pmp_pkg::CSF_ONE);
    assign one_is_select = (chip_select_function == pmp_pkg::CSF_BOTH);

    // Bit 15: second select or address bit
    assign map.cs2 = two_is_select & addr_reg[pmp_pkg::BIT_SEL_TWO];
    assign map.addr[pmp_pkg::BIT_SEL_TWO] =
        ~two_is_select & addr_reg[pmp_pkg::BIT_SEL_TWO];

    // Bit 14: first select or address bit
    assign map.cs1 = one_is_select & addr_reg[pmp_pkg::BIT_SEL_ONE];
    assign map.addr[pmp_pkg::BIT_SEL_ONE] =
        ~one_is_select & addr_reg[pmp_pkg::BIT_SEL_ONE];

    // Low address bits always pass
    assign map.addr[pmp_pkg::LOW_ADDR_MSB:0] =
        addr_reg[pmp_pkg::LOW_ADDR_MSB:0];

endmodule

// >>> hdl/pmp_dual_buffer.sv
// Parallel master port with dual-buffer address and read data registers
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module pmp_dual_buffer #(
    parameter int STROBE = pmp_pkg::STROBE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [15:0] port_addr,
    output logic             port_cs1,
    output logic             port_cs2,
    output logic             port_wr_strobe,
    output logic             port_rd_strobe,
    output logic      [15:0] port_data_out,
    output logic             port_data_oe,
    input  wire logic [15:0] port_data_in
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                     dual;
    logic [1:0]               chip_select_function;
    logic [15:0]              write_target_address;
    logic [15:0]              read_target_address;
    logic [15:0]              read_input_data;
    logic [15:0]              shared_data_input;
    logic [15:0]              shared_address;
    logic [15:0]              write_data;
    logic [15:0]              data_sync;
    pmp_pkg::port_state_t     state;
    logic [pmp_pkg::CNT_W-1:0] cnt;
    localparam int SYNC_LAG = 2;
    logic [SYNC_LAG-1:0]      cap_pipe;

    wire access;
    wire rd_sample;
    wire wr_en;
    wire sel_control;
    wire sel_shared_data;
    wire sel_write_addr;
    wire sel_read_addr;
    wire sel_read_data;
    wire sel_write_data;
    wire sel_shared_addr;
    wire hit;
    wire busy;
    wire write_go;
    wire read_go;
    wire capture;
    wire capture_late;
    wire last_cycle;
    wire [15:0] write_src;
    wire [15:0] read_src;
    wire [31:0] ctrl_word;
    wire [31:0] rd_word;
    wire [pmp_pkg::CNT_W-1:0] cnt_load;

    addr_map_if wmap ();
    addr_map_if rmap ();

    // ************************************************************
    // Pin input synchroniser
    // ************************************************************
    sync2 #(
        .WIDTH (pmp_pkg::DATA_W)
    ) u_data_sync (
        .clk (clk),
        .rst (rst),
        .d   (port_data_in),
        .q   (data_sync)
    );

    // ************************************************************
    // Address source selection and mapping
    // ************************************************************

    // Dual mode picks the separate registers, else the shared one
    assign write_src = dual ? write_target_address : shared_address;
    assign read_src  = dual ? read_target_address : shared_address;

    // Write side mapping
    addr_mapper u_write_map (
        .chip_select_function      (chip_select_function),
        .addr_reg (write_src),
        .map      (wmap)
    );

    // Read side mapping
    addr_mapper u_read_map (
        .chip_select_function      (chip_select_function),
        .addr_reg (read_src),
        .map      (rmap)
    );

    // ************************************************************
    // APB decode
    // ************************************************************

    // Access phase and the edge that completes it
    assign access    = psel & penable;
    assign rd_sample = access & ~pready;
    assign wr_en     = access & pready & pwrite;

    // Register selects on the aligned byte address
    assign sel_control     = (paddr == pmp_pkg::OFF_CONTROL);
    assign sel_shared_data = (paddr == pmp_pkg::OFF_SHARED_DATA);
    assign sel_write_addr  = (paddr == pmp_pkg::OFF_WRITE_ADDR);
    assign sel_read_addr   = (paddr == pmp_pkg::OFF_READ_ADDR);
    assign sel_read_data   = (paddr == pmp_pkg::OFF_READ_DATA);
    assign sel_write_data  = (paddr == pmp_pkg::OFF_WRITE_DATA);
    assign sel_shared_addr = (paddr == pmp_pkg::OFF_SHARED_ADDR);
    assign hit = sel_control | sel_shared_data | sel_write_addr |
                 sel_read_addr | sel_read_data | sel_write_data |
                 sel_shared_addr;

    // Transaction launches; ignored while a transaction runs
    assign busy     = (state != pmp_pkg::ST_IDLE) | (|cap_pipe);
    assign write_go = wr_en & sel_write_data & ~busy;
    assign read_go  = wr_en & sel_control & pwdata[pmp_pkg::BIT_READ_GO] &
                      ~busy;

    // ************************************************************
    // Read data assembly
    // ************************************************************

    // Control word with live busy flag; read-go always reads zero
    assign ctrl_word = {14'h0000, dual, 8'h00, busy, chip_select_function, 6'h00};

    // Upper halves read as zero for every register except control, which carries dual in bit 17
    assign rd_word =
        sel_control     ? ctrl_word :
        sel_shared_data ? {pmp_pkg::UPPER_ZERO, shared_data_input} :
        sel_write_addr  ? {pmp_pkg::UPPER_ZERO, write_target_address} :
        sel_read_addr   ? {pmp_pkg::UPPER_ZERO, read_target_address} :
        sel_read_data   ? {pmp_pkg::UPPER_ZERO, read_input_data} :
        sel_write_data  ? {pmp_pkg::UPPER_ZERO, write_data} :
        sel_shared_addr ? {pmp_pkg::UPPER_ZERO, shared_address} :
                          pmp_pkg::WORD_ZERO;

    // ************************************************************
    // APB answer
    // ************************************************************

    // One wait state lets every answer come from a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= pmp_pkg::WORD_ZERO;
        end else begin
            pready  <= rd_sample;
            pslverr <= rd_sample & ~hit;
            if (rd_sample) begin
                prdata <= pwrite ? pmp_pkg::WORD_ZERO : rd_word;
            end
        end
    end

    // ************************************************************
    // Software registers
    // ************************************************************

    // Control, address and write data registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dual                 <= 1'b0;
            chip_select_function                  <= pmp_pkg::CSF_ADDR;
            write_target_address <= pmp_pkg::FIELD_RESET;
            read_target_address  <= pmp_pkg::FIELD_RESET;
            shared_address       <= pmp_pkg::FIELD_RESET;
            write_data           <= pmp_pkg::FIELD_RESET;
        end else if (wr_en) begin
            if (sel_control) begin
                dual <= pwdata[pmp_pkg::BIT_DUAL];
                chip_select_function  <= pwdata[pmp_pkg::CSF_HI:pmp_pkg::CSF_LO];
            end
            if (sel_write_addr) begin
                write_target_address <= pwdata[15:0];
            end
            if (sel_read_addr) begin
                read_target_address <= pwdata[15:0];
            end
            if (sel_shared_addr) begin
                shared_address <= pwdata[15:0];
            end
            if (sel_write_data) begin
                write_data <= pwdata[15:0];
            end
        end
    end

    // Capture of port data at the end of a read strobe
    assign last_cycle = (cnt == '0);
    assign capture    = (state == pmp_pkg::ST_READ) & last_cycle;

    // Pin data reaches data_sync only after the synchroniser lag, so the
    // store waits that long to take what stood in the last strobe cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_pipe <= '0;
        end else begin
            cap_pipe <= {cap_pipe[SYNC_LAG-2:0], capture};
        end
    end
    assign capture_late = cap_pipe[SYNC_LAG-1];

    // Captured data beats a software write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_input_data   <= pmp_pkg::FIELD_RESET;
            shared_data_input <= pmp_pkg::FIELD_RESET;
        end else begin
            if (capture_late & dual) begin
                read_input_data <= data_sync;
            end else if (wr_en & sel_read_data) begin
                read_input_data <= pwdata[15:0];
            end
            if (capture_late & ~dual) begin
                shared_data_input <= data_sync;
            end else if (wr_en & sel_shared_data) begin
                shared_data_input <= pwdata[15:0];
            end
        end
    end

    // ************************************************************
    // Port transaction sequencer
    // ************************************************************
    assign cnt_load = pmp_pkg::CNT_W'(STROBE - 1);

    // Address and selects latched at launch stay for the whole strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state          <= pmp_pkg::ST_IDLE;
            cnt            <= '0;
            port_addr      <= pmp_pkg::FIELD_RESET;
            port_cs1       <= 1'b0;
            port_cs2       <= 1'b0;
            port_wr_strobe <= 1'b0;
            port_rd_strobe <= 1'b0;
            port_data_out  <= pmp_pkg::FIELD_RESET;
            port_data_oe   <= 1'b0;
        end else begin
            case (state)
                pmp_pkg::ST_IDLE: begin
                    if (write_go) begin
                        state          <= pmp_pkg::ST_WRITE;
                        cnt            <= cnt_load;
                        port_addr      <= wmap.addr;
                        port_cs1       <= wmap.cs1;
                        port_cs2       <= wmap.cs2;
                        port_data_out  <= pwdata[15:0];
                        port_data_oe   <= 1'b1;
                        port_wr_strobe <= 1'b1;
                    end else if (read_go) begin
                        state          <= pmp_pkg::ST_READ;
                        cnt            <= cnt_load;
                        port_addr      <= rmap.addr;
                        port_cs1       <= rmap.cs1;
                        port_cs2       <= rmap.cs2;
                        port_rd_strobe <= 1'b1;
                    end
                end
                pmp_pkg::ST_WRITE,
                pmp_pkg::ST_READ: begin
                    if (last_cycle) begin
                        state          <= pmp_pkg::ST_IDLE;
                        port_cs1       <= 1'b0;
                        port_cs2       <= 1'b0;
                        port_wr_strobe <= 1'b0;
                        port_rd_strobe <= 1'b0;
                        port_data_oe   <= 1'b0;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: begin
                    state <= pmp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Select two on writes follows bit 15 in select modes
    property p_write_select_two;
        $rose(port_wr_strobe) && $past(chip_select_function) inside {2'b10, 2'b01} |->
            port_cs2 == $past(write_src[15]) && !port_addr[15];
    endproperty
    a_write_select_two : assert property (p_write_select_two)
        else $error("write select two does not follow bit 15");

    // Bit 15 is address in plain mode
    property p_waddr15;
        $rose(port_wr_strobe) && $past(chip_select_function) == 2'b00 |->
            port_addr[15] == $past(write_src[15]) && !port_cs2;
    endproperty
    a_waddr15 : assert property (p_waddr15)
        else $error("write address bit 15 wrong in plain mode");

    // Select one on writes only in both-select mode
    property p_write_select_one;
        $rose(port_wr_strobe) && $past(chip_select_function) == 2'b10 |->
            port_cs1 == $past(write_src[14]) && !port_addr[14];
    endproperty
    a_write_select_one : assert property (p_write_select_one)
        else $error("write select one does not follow bit 14");

    // Bit 14 is address in plain and one-select modes
    property p_waddr14;
        $rose(port_wr_strobe) && $past(chip_select_function) inside {2'b00, 2'b01} |->
            port_addr[14] == $past(write_src[14]) && !port_cs1;
    endproperty
    a_waddr14 : assert property (p_waddr14)
        else $error("write address bit 14 wrong");

    // Low write address and dual-mode source
    property p_wlow;
        $rose(port_wr_strobe) && $past(dual) |->
            port_addr[13:0] == $past(write_target_address[13:0]);
    endproperty
    a_wlow : assert property (p_wlow)
        else $error("low write address bits wrong");

    // Read chip selects two and one
    property p_rsel;
        $rose(port_rd_strobe) |->
            port_cs2 == ($past(chip_select_function) inside {2'b10, 2'b01} &&
                         $past(read_src[15])) &&
            port_cs1 == ($past(chip_select_function) == 2'b10 && $past(read_src[14]));
    endproperty
    a_rsel : assert property (p_rsel)
        else $error("read chip selects wrong");

    // Low read address from the read register in dual mode
    property p_rlow;
        $rose(port_rd_strobe) && $past(dual) |->
            port_addr[13:0] == $past(read_target_address[13:0]);
    endproperty
    a_rlow : assert property (p_rlow)
        else $error("low read address bits wrong");

    // Shared address used when dual is clear
    property p_shared_src;
        $rose(port_wr_strobe) && !$past(dual) && $past(chip_select_function) == 2'b00 |->
            port_addr == $past(shared_address);
    endproperty
    a_shared_src : assert property (p_shared_src)
        else $error("single mode did not use shared address");

    // Dual read lands in the read input register only
    property p_dual_capture;
        $fell(port_rd_strobe) && $past(dual) |->
            ##2 (read_input_data == $past(data_sync) &&
            $stable(shared_data_input));
    endproperty
    a_dual_capture : assert property (p_dual_capture)
        else $error("dual read data not in read input register");

    // Single read lands in the shared register only
    property p_single_capture;
        $fell(port_rd_strobe) && !$past(dual) |->
            ##2 (shared_data_input == $past(data_sync) &&
            $stable(read_input_data));
    endproperty
    a_single_capture : assert property (p_single_capture)
        else $error("single read data not in shared register");

    // Upper half of address and data registers reads zero
    property p_upper_zero;
        pready && !pwrite && !sel_control |-> prdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero : assert property (p_upper_zero)
        else $error("upper read bits not zero");

    // Write strobe lasts two cycles and then falls
    property p_strobe_len;
        $rose(port_wr_strobe) |-> port_wr_strobe[*2] ##1 !port_wr_strobe;
    endproperty
    a_strobe_len : assert property (p_strobe_len)
        else $error("write strobe length wrong");

endmodule

// >>> hdl/pmp_pkg.sv
// Constants, field positions and types shared by the parallel port files
package pmp_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int PADDR_W = 8;
    localparam int CNT_W = 4;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_CONTROL      = 8'h00;
    localparam logic [7:0] OFF_SHARED_DATA  = 8'h04;
    localparam logic [7:0] OFF_WRITE_ADDR   = 8'h08;
    localparam logic [7:0] OFF_READ_ADDR    = 8'h0C;
    localparam logic [7:0] OFF_READ_DATA    = 8'h10;
    localparam logic [7:0] OFF_WRITE_DATA   = 8'h14;
    localparam logic [7:0] OFF_SHARED_ADDR  = 8'h18;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int BIT_DUAL     = 17;
    localparam int BIT_BUSY     = 8;
    localparam int CSF_HI       = 7;
    localparam int CSF_LO       = 6;
    localparam int BIT_READ_GO  = 0;
    localparam int BIT_SEL_TWO  = 15;
    localparam int BIT_SEL_ONE  = 14;
    localparam int LOW_ADDR_MSB = 13;
    localparam logic [15:0] FIELD_RESET = 16'h0000;
    localparam logic [15:0] UPPER_ZERO  = 16'h0000;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

    // ************************************************************
    // Modes, states and timing
    // ************************************************************
    typedef enum logic [1:0] {
        CSF_ADDR = 2'b00,
        CSF_ONE  = 2'b01,
        CSF_BOTH = 2'b10,
        CSF_RSVD = 2'b11
    } csf_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10
    } port_state_t;

    localparam int CLK_MHZ   = 40;
    localparam int STROBE_NS = 50;
    // Least time, so round up to whole cycles
    localparam int STROBE_CYCLES = (STROBE_NS * CLK_MHZ + 999) / 1000;

endpackage

// >>> hdl/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage;

    // ************************************************************
    // Synchroniser
    // ************************************************************

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage <= '0;
            q     <= '0;
        end else begin
            stage <= d;
            q     <= stage;
        end
    end

endmodule

// >>> tb/parallel_peripheral_model.sv
// Behavioural peripheral that answers port reads from its address lines
`timescale 1ns/1ps
module parallel_peripheral_model (
    input  wire logic        clk,
    input  wire logic [15:0] port_addr,
    input  wire logic        port_rd_strobe,
    output logic      [15:0] port_data_in
);
    // ************************************************************
    // Read answer
    // ************************************************************
    localparam logic [15:0] SCRAMBLE = 16'h5A3C;
    logic [15:0] last;

    // Released bus shows the inverse of its last value, never a stale copy
    always_comb begin
        port_data_in = port_rd_strobe ? port_addr ^ SCRAMBLE : ~last;
    end

    // Remember what was on the bus
    always_ff @(posedge clk) begin
        last <= port_data_in;
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the dual-buffer parallel port
`timescale 1ns/1ps
module tb_top;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] port_addr, port_data_out, port_data_in, pins;
    logic        port_cs1, port_cs2, port_wr_strobe, port_rd_strobe;
    logic        port_data_oe;
    int          failures, compares, cycles;

    pmp_dual_buffer DUT (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_addr(port_addr), .port_cs1(port_cs1),
        .port_cs2(port_cs2), .port_wr_strobe(port_wr_strobe),
        .port_rd_strobe(port_rd_strobe), .port_data_out(port_data_out),
        .port_data_oe(port_data_oe), .port_data_in(port_data_in));
    parallel_peripheral_model PEER (.clk(clk), .port_addr(port_addr),
        .port_rd_strobe(port_rd_strobe), .port_data_in(port_data_in));

    // Free-running clock, 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h0000_0001, {31'h0000_0000, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk("register", exp, rd);
    endtask

    // Waits for a strobe, judges pins, then waits for the bus to go idle
    task automatic watch(input logic rdir, input logic [1:0] chip_select_function,
                         input logic [15:0] a, input logic [15:0] d);
        int n;
        logic [17:0] exp;
        exp = {(chip_select_function == 2'b01 || chip_select_function == 2'b10) & a[15],
               chip_select_function == 2'b10 & a[14],
               (chip_select_function == 2'b00 || chip_select_function == 2'b11) & a[15],
               chip_select_function != 2'b10 & a[14], a[13:0]};
        pins = exp[15:0];
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((rdir ? port_rd_strobe : port_wr_strobe) !== 1'b1
                   && n < 10);
        chk("pins", {14'h0000, exp}, {14'h0000, port_cs2, port_cs1,
            port_addr});
        chk("drive", {15'h0000, ~rdir, rdir ? port_data_out : d},
            {15'h0000, port_data_oe, port_data_out});
        do begin
            @(posedge clk);
            n++;
        end while ((port_rd_strobe | port_wr_strobe) && n < 30);
        chk("cs idle", 32'h0000_0000, {30'h0, port_cs2, port_cs1});
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rdchk(pmp_pkg::OFF_WRITE_ADDR, 32'h0000_0000);
        rdchk(pmp_pkg::OFF_READ_ADDR, 32'h0000_0000);
        rdchk(pmp_pkg::OFF_READ_DATA, 32'h0000_0000);
    endtask

    task automatic t_upper_bits();
        apb(1'b1, pmp_pkg::OFF_WRITE_ADDR, 32'hFFFF_FFFF);
        rdchk(pmp_pkg::OFF_WRITE_ADDR, 32'h0000_FFFF);
        apb(1'b1, pmp_pkg::OFF_READ_ADDR, 32'hFFFF_FFFF);
        rdchk(pmp_pkg::OFF_READ_ADDR, 32'h0000_FFFF);
        apb(1'b1, pmp_pkg::OFF_READ_DATA, 32'hFFFF_FFFF);
        rdchk(pmp_pkg::OFF_READ_DATA, 32'h0000_FFFF);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
    endtask

    // Writes under each select function, read address set elsewhere
    task automatic t_writes();
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, pmp_pkg::OFF_CONTROL, 32'h0002_0000 | (f << 6));
            apb(1'b1, pmp_pkg::OFF_READ_ADDR, 32'h0000_3A5A);
            apb(1'b1, pmp_pkg::OFF_WRITE_ADDR, 32'h0000_C123);
            apb(1'b1, pmp_pkg::OFF_WRITE_DATA, 32'h0000_B00F + f);
            watch(1'b0, 2'(f), 16'hC123, 16'hB00F + 16'(f));
        end
    endtask

    // Reads land in the dedicated register, shared one untouched
    task automatic t_reads();
        for (int f = 0; f < 3; f++) begin
            apb(1'b1, pmp_pkg::OFF_CONTROL, 32'h0002_0000 | (f << 6));
            apb(1'b1, pmp_pkg::OFF_READ_ADDR, 32'h0000_C0A5);
            apb(1'b1, pmp_pkg::OFF_WRITE_ADDR, 32'h0000_0F0F);
            apb(1'b1, pmp_pkg::OFF_CONTROL, 32'h0002_0001 | (f << 6));
            watch(1'b1, 2'(f), 16'hC0A5, 16'h0000);
            rdchk(pmp_pkg::OFF_READ_DATA, {16'h0000, pins ^ 16'h5A3C});
            rdchk(pmp_pkg::OFF_SHARED_DATA, 32'h0000_0000);
        end
    endtask

    // Without dual mode the shared address and data registers serve
    task automatic t_shared();
        logic [15:0] kept;
        kept = pins ^ 16'h5A3C;
        apb(1'b1, pmp_pkg::OFF_SHARED_ADDR, 32'h0000_1234);
        apb(1'b1, pmp_pkg::OFF_CONTROL, 32'h0000_0000);
        apb(1'b1, pmp_pkg::OFF_CONTROL, 32'h0000_0001);
        watch(1'b1, 2'b00, 16'h1234, 16'h0000);
        rdchk(pmp_pkg::OFF_SHARED_DATA, 32'h0000_4808);
        rdchk(pmp_pkg::OFF_READ_DATA, {16'h0000, kept});
        apb(1'b1, pmp_pkg::OFF_WRITE_DATA, 32'h0000_5AA5);
        watch(1'b0, 2'b00, 16'h1234, 16'h5AA5);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        failures = 0;
        compares = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_upper_bits();
        t_writes();
        t_reads();
        t_shared();
        report_and_stop();
    end
endmodule
